// *** src/bpg_pkg.sv ***
// shared constants and types for the two-port gpio block
package bpg_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned A_W = 6;
    localparam int unsigned B_W = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FIRST_PINS = 8'h05;
    localparam logic [7:0] IDX_SECOND_PINS = 8'h06;
    localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0b;
    localparam logic [7:0] IDX_OPTION_CONFIG = 8'h81;
    localparam logic [7:0] IDX_FIRST_DIR = 8'h85;
    localparam logic [7:0] IDX_SECOND_DIR = 8'h86;
    localparam logic [7:0] IDX_ANALOG_CFG = 8'h9f;
    localparam logic [7:0] IDX_PERIPH_SHARE = 8'ha0;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned OPT_PULLUP_DIS_N = 7;
    localparam int unsigned IRQ_CHANGE_FLAG = 0;
    localparam int unsigned IRQ_CHANGE_EN = 3;
    localparam int unsigned PERIPH_T0_EN = 0;
    localparam int unsigned PIN_OPEN_DRAIN = 4;
    localparam int unsigned SENSE_LO = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_OPTION = 8'hff;
    localparam logic [7:0] RST_IRQ = 8'h00;
    localparam logic [7:0] RST_ANALOG = 8'h00;
    localparam logic [7:0] RST_PERIPH = 8'h00;

    localparam logic [5:0] ANA_ALL = 6'h2f;
    localparam logic [5:0] ANA_PART = 6'h0b;
    localparam logic [5:0] ANA_NONE = 6'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } bpg_apb_st_t;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    // pins of the first port that the analog mux owns for a given config code
    function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
        case (cfg)
            3'h0: return ANA_ALL;
            3'h6, 3'h7: return ANA_NONE;
            default: return ANA_PART;
        endcase
    endfunction

endpackage

// *** src/bpg_port_if.sv ***
// carrier between the port core and its pad bank and change detector
`timescale 1ns/1ps
`default_nettype none
interface bpg_port_if #(parameter int W = 8);
    logic [W-1:0] dir;
    logic [W-1:0] latch;
    logic [W-1:0] pin_in;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe;
    logic [W-1:0] level;
    logic capture;
    logic mismatch;
    modport bank (input dir, latch, pin_in, output pin_out, pin_oe, level);
    modport sense (input dir, level, capture, output mismatch);
    modport core (output dir, latch, pin_in, capture, input pin_out, pin_oe, level, mismatch);
endinterface
`default_nettype wire

// *** src/bpg_pad_bank.sv ***
// per-pin driver and input path of one port
`timescale 1ns/1ps
`default_nettype none
module bpg_pad_bank #(parameter int W = 8) (
    bpg_port_if.bank port
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_pin
            // a set direction bit floats the driver
            assign port.pin_oe[i] = ~port.dir[i];
            assign port.pin_out[i] = port.latch[i];
            assign port.level[i] = port.pin_in[i];
        end
    endgenerate
endmodule // bpg_pad_bank
`default_nettype wire

// *** src/bpg_change_det.sv ***
// mismatch detector for the upper pins of the second port
`timescale 1ns/1ps
`default_nettype none
module bpg_change_det #(parameter int W = 8, parameter int LO = 4) (
    input wire logic pclk,
    input wire logic presetn,
    bpg_port_if.sense port
);
    typedef struct packed {
        logic [W-LO-1:0] snap;
    } bpg_det_state_t;

    bpg_det_state_t q;
    bpg_det_state_t d;

    always_comb
    begin
        d = q;
        if (port.capture)
        begin
            d.snap = port.level[W-1:LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs are excluded from the compare
    assign port.mismatch = |((port.level[W-1:LO] ^ q.snap) & port.dir[W-1:LO]);

    property p_snap_taken;
        @(posedge pclk) disable iff (!presetn)
        port.capture |=> q.snap == $past(port.level[W-1:LO]);
    endproperty
    a_snap_taken: assert property (p_snap_taken) else $error("snapshot not taken");

    property p_out_excluded;
        @(posedge pclk) disable iff (!presetn)
        (port.dir[W-1:LO] == '0) |-> !port.mismatch;
    endproperty
    a_out_excluded: assert property (p_out_excluded) else $error("output pin compared");

    c_capture: cover property (@(posedge pclk) disable iff (!presetn)
        port.capture ##1 port.mismatch);
endmodule // bpg_change_det
`default_nettype wire

// *** src/bpg_gpio_ports.sv ***
// two general purpose ports behind an apb register slave
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - first port has six pins, each with a latch bit and direction bit.
// - direction one floats a first-port pin; zero drives the latch value.
// - port reads return pin levels; writes load the output latch.
// - port writes sample pins, change addressed bits, store whole latch.
// - first-port bit 4 doubles as timer clock input and only pulls low.
// - other first-port pins share analog inputs, chosen by analog config bits.
// - after reset analog pins are analog inputs and read as zero.
// - first-port direction bits still steer drivers on analog pins.
// - an enabled sharing peripheral takes its pin away from the port.
// - second port has eight pins with the same direction meaning.
// - clearing option bit 7 enables all second-port pull-ups together.
// - pull-up is off on any second-port pin set as output.
// - all second-port pull-ups are off after reset.
// - only input pins among second-port bits 7 to 4 sense changes.
// - sensing pins compare against snapshot from last second-port read or write.
// - mismatches are ORed into the change flag, irq control bit 0.
// - a port change can wake the device from sleep.
// - second-port read or write ends mismatch; software clears the flag.
// - a lasting mismatch keeps setting the change flag.
module bpg_gpio_ports (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bpg_pkg::ADDR_W-1:0] paddr,
    input wire logic [bpg_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [bpg_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic [bpg_pkg::A_W-1:0] pa_in,
    output logic [bpg_pkg::A_W-1:0] pa_out,
    output logic [bpg_pkg::A_W-1:0] pa_oe,
    input wire logic [bpg_pkg::B_W-1:0] pb_in,
    output logic [bpg_pkg::B_W-1:0] pb_out,
    output logic [bpg_pkg::B_W-1:0] pb_oe,
    output logic [bpg_pkg::B_W-1:0] pb_pullup_en,
    output logic timer0_ext_clock_in,
    output logic port_change_wake
);
    typedef struct packed {
        bpg_pkg::bpg_apb_st_t st;
        logic [5:0] latch_a;
        logic [5:0] dir_a;
        logic [7:0] latch_b;
        logic [7:0] dir_b;
        logic [7:0] option;
        logic [7:0] irq;
        logic [7:0] analog;
        logic [7:0] periph;
        logic [31:0] rdata;
        logic err;
    } bpg_core_state_t;

    bpg_core_state_t q;
    bpg_core_state_t d;

    bpg_port_if #(.W(bpg_pkg::A_W)) ifa ();
    bpg_port_if #(.W(bpg_pkg::B_W)) ifb ();

    logic setup;
    logic done;
    logic hit;
    logic sel_a;
    logic sel_b;
    logic sel_dir_a;
    logic [7:0] rd_val;
    logic [5:0] ana;
    logic [5:0] rd_a;
    logic od_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // pin side

    bpg_pad_bank #(.W(bpg_pkg::A_W)) u_bank_a (
        .port(ifa.bank)
    );

    bpg_pad_bank #(.W(bpg_pkg::B_W)) u_bank_b (
        .port(ifb.bank)
    );

    bpg_change_det #(.W(bpg_pkg::B_W), .LO(bpg_pkg::SENSE_LO)) u_change (
        .pclk(pclk),
        .presetn(presetn),
        .port(ifb.sense)
    );

    assign ifa.dir = q.dir_a;
    assign ifa.latch = q.latch_a;
    assign ifa.pin_in = pa_in;
    assign ifa.capture = 1'b0;
    assign ifa.mismatch = 1'b0;
    assign ifb.dir = q.dir_b;
    assign ifb.latch = q.latch_b;
    assign ifb.pin_in = pb_in;

    // analog pins read zero, and the rmw write-back inherits those zeros
    assign ana = bpg_pkg::analog_mask(q.analog[2:0]);
    assign rd_a = ifa.level & ~ana;

    // open drain: never driven high, and released while the timer owns it
    assign od_oe = ~q.dir_a[bpg_pkg::PIN_OPEN_DRAIN] & ~q.latch_a[bpg_pkg::PIN_OPEN_DRAIN]
        & ~q.periph[bpg_pkg::PERIPH_T0_EN];

    always_comb
    begin
        pa_out = ifa.pin_out;
        pa_oe = ifa.pin_oe;
        pa_out[bpg_pkg::PIN_OPEN_DRAIN] = 1'b0;
        pa_oe[bpg_pkg::PIN_OPEN_DRAIN] = od_oe;
    end

    assign timer0_ext_clock_in = ifa.level[bpg_pkg::PIN_OPEN_DRAIN];
    assign pb_out = ifb.pin_out;
    assign pb_oe = ifb.pin_oe;
    assign pb_pullup_en = {bpg_pkg::B_W{~q.option[bpg_pkg::OPT_PULLUP_DIS_N]}} & q.dir_b;
    // wake does not depend on any global enable
    assign port_change_wake = q.irq[bpg_pkg::IRQ_CHANGE_FLAG]
        & q.irq[bpg_pkg::IRQ_CHANGE_EN];

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode

    assign setup = psel & ~penable;
    assign pready = (q.st == bpg_pkg::ST_ACCESS);
    assign done = psel & penable & pready;
    assign prdata = q.rdata;
    assign pslverr = pready & q.err;
    assign sel_a = (paddr == bpg_pkg::reg_addr(bpg_pkg::IDX_FIRST_PINS));
    assign sel_b = (paddr == bpg_pkg::reg_addr(bpg_pkg::IDX_SECOND_PINS));
    assign sel_dir_a = (paddr == bpg_pkg::reg_addr(bpg_pkg::IDX_FIRST_DIR));
    // any second-port access re-arms the compare, reads and writes alike
    assign ifb.capture = done & sel_b;

    always_comb
    begin
        hit = 1'b1;
        rd_val = 8'h00;
        case (paddr)
            bpg_pkg::reg_addr(bpg_pkg::IDX_FIRST_PINS): rd_val = {2'h0, rd_a};
            bpg_pkg::reg_addr(bpg_pkg::IDX_SECOND_PINS): rd_val = ifb.level;
            bpg_pkg::reg_addr(bpg_pkg::IDX_IRQ_CONTROL): rd_val = q.irq;
            bpg_pkg::reg_addr(bpg_pkg::IDX_OPTION_CONFIG): rd_val = q.option;
            bpg_pkg::reg_addr(bpg_pkg::IDX_FIRST_DIR): rd_val = {2'h0, q.dir_a};
            bpg_pkg::reg_addr(bpg_pkg::IDX_SECOND_DIR): rd_val = q.dir_b;
            bpg_pkg::reg_addr(bpg_pkg::IDX_ANALOG_CFG): rd_val = q.analog;
            bpg_pkg::reg_addr(bpg_pkg::IDX_PERIPH_SHARE): rd_val = q.periph;
            default: hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state update

    always_comb
    begin
        d = q;
        case (q.st)
            bpg_pkg::ST_IDLE:
            begin
                if (setup)
                begin
                    d.st = bpg_pkg::ST_ACCESS;
                    d.rdata = {24'h000000, rd_val};
                    d.err = ~hit;
                end
            end
            bpg_pkg::ST_ACCESS:
            begin
                if (psel && penable)
                begin
                    d.st = bpg_pkg::ST_IDLE;
                end
            end
            default: d.st = bpg_pkg::ST_IDLE;
        endcase
        if (done && pwrite && !q.err)
        begin
            // a port write stores the whole latch; unstrobed bits keep pin levels
            if (sel_a)
            begin
                d.latch_a = pstrb[0] ? pwdata[5:0] : rd_a;
            end
            if (sel_b)
            begin
                d.latch_b = pstrb[0] ? pwdata[7:0] : ifb.level;
            end
            if (pstrb[0])
            begin
                case (paddr)
                    bpg_pkg::reg_addr(bpg_pkg::IDX_IRQ_CONTROL): d.irq = pwdata[7:0];
                    bpg_pkg::reg_addr(bpg_pkg::IDX_OPTION_CONFIG): d.option = pwdata[7:0];
                    bpg_pkg::reg_addr(bpg_pkg::IDX_FIRST_DIR): d.dir_a = pwdata[5:0];
                    bpg_pkg::reg_addr(bpg_pkg::IDX_SECOND_DIR): d.dir_b = pwdata[7:0];
                    bpg_pkg::reg_addr(bpg_pkg::IDX_ANALOG_CFG): d.analog = pwdata[7:0];
                    bpg_pkg::reg_addr(bpg_pkg::IDX_PERIPH_SHARE): d.periph = pwdata[7:0];
                    default: d.err = q.err;
                endcase
            end
        end
        // set wins over a software clear in the same cycle
        if (ifb.mismatch)
        begin
            d.irq[bpg_pkg::IRQ_CHANGE_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q.st <= bpg_pkg::ST_IDLE;
            q.latch_a <= bpg_pkg::RST_LATCH[5:0];
            q.dir_a <= bpg_pkg::RST_DIR[5:0];
            q.latch_b <= bpg_pkg::RST_LATCH;
            q.dir_b <= bpg_pkg::RST_DIR;
            q.option <= bpg_pkg::RST_OPTION;
            q.irq <= bpg_pkg::RST_IRQ;
            q.analog <= bpg_pkg::RST_ANALOG;
            q.periph <= bpg_pkg::RST_PERIPH;
            q.rdata <= 32'h00000000;
            q.err <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_dir_drive;
        done && pwrite && sel_dir_a && pstrb[0] && !pwdata[0]
            |=> pa_oe[0] && (pa_out[0] == q.latch_a[0]);
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("cleared direction not driving");

    property p_read_pins;
        setup && sel_a && !pwrite ##1 done |-> prdata[5:0] == $past(pa_in & ~ana);
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("read did not return pins");

    property p_rmw;
        done && pwrite && sel_b && !pstrb[0] |=> q.latch_b == $past(pb_in);
    endproperty
    a_rmw: assert property (p_rmw) else $error("write did not merge pin levels");

    property p_open_drain;
        pa_oe[4] |-> !pa_out[4] && !q.latch_a[4] && !q.dir_a[4];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain pin driven high");

    property p_analog_zero;
        done && sel_a && !pwrite |-> (prdata[5:0] & ana) == 6'h00;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

    property p_timer_pin;
        q.periph[0] |-> !pa_oe[4];
    endproperty
    a_timer_pin: assert property (p_timer_pin) else $error("timer pin still driven");

    property p_pullup_off;
        q.option[7] || (q.dir_b != 8'hff) |-> (pb_pullup_en & ~q.dir_b) == 8'h00
            && (!q.option[7] || pb_pullup_en == 8'h00);
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up active wrongly");

    property p_flag_set;
        ifb.mismatch |=> q.irq[0] && (port_change_wake == q.irq[3]);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("change flag not set");

    property p_dir_upper;
        done && sel_dir_a && !pwrite |-> prdata[7:6] == 2'h0;
    endproperty
    a_dir_upper: assert property (p_dir_upper) else $error("upper direction bits nonzero");

    property p_latch_load;
        done && pwrite && sel_a && pstrb[0] |=> q.latch_a == $past(pwdata[5:0]);
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

    property p_rmw_a;
        done && pwrite && sel_a && !pstrb[0] |=> q.latch_a == $past(pa_in & ~ana);
    endproperty
    a_rmw_a: assert property (p_rmw_a) else $error("first port write lost pins");

    property p_timer_in;
        timer0_ext_clock_in == pa_in[4];
    endproperty
    a_timer_in: assert property (p_timer_in) else $error("timer input not pin level");

    property p_analog_dir;
        pa_oe[0] == !q.dir_a[0];
    endproperty
    a_analog_dir: assert property (p_analog_dir) else $error("direction lost on pin");

    property p_b_drive;
        pb_oe == ~q.dir_b && pb_out == q.latch_b;
    endproperty
    a_b_drive: assert property (p_b_drive) else $error("second port drive wrong");

    property p_pullup_on;
        !q.option[7] |-> pb_pullup_en == q.dir_b;
    endproperty
    a_pullup_on: assert property (p_pullup_on) else $error("pull-ups not enabled");

    property p_wake_flag;
        port_change_wake |-> q.irq[0];
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake without change flag");

    property p_flag_clear;
        done && pwrite && pstrb[0] && paddr == bpg_pkg::reg_addr(bpg_pkg::IDX_IRQ_CONTROL)
            && !pwdata[0] && !ifb.mismatch |=> !q.irq[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("change flag not cleared");

    property p_access_next;
        setup && q.st == bpg_pkg::ST_IDLE |=> pready;
    endproperty
    a_access_next: assert property (p_access_next) else $error("no access cycle after setup");

    c_read_a: cover property (done && sel_a && !pwrite);
    c_rmw_b: cover property (done && pwrite && sel_b && !pstrb[0]);
    c_wake: cover property ($rose(port_change_wake));
endmodule // bpg_gpio_ports
`default_nettype wire

// *** tb/bpg_pin_board.sv ***
// board-side model of the pins of both ports
`timescale 1ns/1ps
`default_nettype none
module bpg_pin_board (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [bpg_pkg::A_W-1:0] pa_out,
    input wire logic [bpg_pkg::A_W-1:0] pa_oe,
    input wire logic [bpg_pkg::B_W-1:0] pb_out,
    input wire logic [bpg_pkg::B_W-1:0] pb_oe,
    input wire logic [bpg_pkg::B_W-1:0] pb_pullup_en,
    input wire logic [bpg_pkg::A_W-1:0] board_pa_val,
    input wire logic [bpg_pkg::A_W-1:0] board_pa_en,
    input wire logic [bpg_pkg::B_W-1:0] board_pb_val,
    input wire logic [bpg_pkg::B_W-1:0] board_pb_en,
    output logic [bpg_pkg::A_W-1:0] pa_in,
    output logic [bpg_pkg::B_W-1:0] pb_in
);
    typedef struct packed {
        logic [bpg_pkg::A_W-1:0] pa;
        logic [bpg_pkg::B_W-1:0] pb;
    } bpg_board_st_t;
    bpg_board_st_t state_q;
    bpg_board_st_t state_d;

    ////////////////////////////////////////////////////////////////////////////////
    // a floating pin with no pull shows the inverse of its last level, so the
    // simulator never hands a stale value back as if it were driven
    always_comb
    begin
        for (int i = 0; i < bpg_pkg::A_W; i++)
        begin
            if (pa_oe[i])
                pa_in[i] = pa_out[i];
            else if (board_pa_en[i])
                pa_in[i] = board_pa_val[i];
            else if (i == bpg_pkg::PIN_OPEN_DRAIN)
                pa_in[i] = 1'b1;
            else
                pa_in[i] = ~state_q.pa[i];
        end
        for (int i = 0; i < bpg_pkg::B_W; i++)
        begin
            if (pb_oe[i])
                pb_in[i] = pb_out[i];
            else if (board_pb_en[i])
                pb_in[i] = board_pb_val[i];
            else if (pb_pullup_en[i])
                pb_in[i] = 1'b1;
            else
                pb_in[i] = ~state_q.pb[i];
        end
        state_d = {pa_in, pb_in};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= '0;
        else
            state_q <= state_d;
    end
endmodule // bpg_pin_board
`default_nettype wire

// *** tb/test_bpg_gpio_ports.sv ***
// self-checking bench of the two-port gpio block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module test_bpg_gpio_ports;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [bpg_pkg::ADDR_W-1:0] paddr = '0;
    logic [bpg_pkg::DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, tclk, wake;
    logic [bpg_pkg::DATA_W-1:0] prdata;
    logic [5:0] pa_in, pa_out, pa_oe;
    logic [7:0] pb_in, pb_out, pb_oe, pb_pu;
    logic [5:0] bpa_val = 6'h00;
    logic [5:0] bpa_en = 6'h00;
    logic [7:0] bpb_val = 8'h00;
    logic [7:0] bpb_en = 8'hff;
    int errors = 0;
    int checks = 0;

    always #20 pclk = ~pclk;

    bpg_gpio_ports i_bpg_gpio_ports (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out),
        .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup_en(pb_pu),
        .timer0_ext_clock_in(tclk), .port_change_wake(wake));
    bpg_pin_board i_bpg_pin_board (.pclk(pclk), .presetn(presetn), .pa_out(pa_out),
        .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup_en(pb_pu),
        .board_pa_val(bpa_val), .board_pa_en(bpa_en), .board_pb_val(bpb_val),
        .board_pb_en(bpb_en), .pa_in(pa_in), .pb_in(pb_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // pready, prdata and pslverr are read in the time step of the rising edge, before
    // its updates land, so they are what that edge samples; release follows at once
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
        input logic s0, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, wd};
        pstrb <= {3'h0, s0};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            errors++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, wd, 1'b1, rd, err);
        cyc(1);
        `CHK("write error", 1'b0, err)
    endtask

    task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic err;
        apb(1'b0, idx, 8'h00, 1'b0, d, err);
        `CHK(nm, {24'h000000, exp}, d)
        `CHK("read error", 1'b0, err)
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        logic err;
        `CHK("pullups after reset", 8'h00, pb_pu)
        `CHK("pa oe after reset", 6'h00, pa_oe)
        rd("option", bpg_pkg::IDX_OPTION_CONFIG, 8'hff);
        rd("dir a", bpg_pkg::IDX_FIRST_DIR, 8'h3f);
        rd("dir b", bpg_pkg::IDX_SECOND_DIR, 8'hff);
        rd("irq", bpg_pkg::IDX_IRQ_CONTROL, 8'h00);
        rd("analog", bpg_pkg::IDX_ANALOG_CFG, 8'h00);
        rd("pa analog", bpg_pkg::IDX_FIRST_PINS, 8'h10);
        wr(bpg_pkg::IDX_FIRST_DIR, 8'hff);
        rd("dir a upper", bpg_pkg::IDX_FIRST_DIR, 8'h3f);
        apb(1'b0, 8'h40, 8'h00, 1'b0, d, err);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h00000000, d)
    endtask

    task automatic t_first_port();
        wr(bpg_pkg::IDX_ANALOG_CFG, 8'h06);
        wr(bpg_pkg::IDX_FIRST_DIR, 8'h00);
        wr(bpg_pkg::IDX_FIRST_PINS, 8'h2a);
        `CHK("pa oe", 6'h3f, pa_oe)
        `CHK("pa out", 6'h2a, pa_out)
        rd("pa pins", bpg_pkg::IDX_FIRST_PINS, 8'h2a);
        wr(bpg_pkg::IDX_FIRST_PINS, 8'h3f);
        `CHK("pa4 released", 6'h2f, pa_oe)
        `CHK("pa4 never high", 1'b0, pa_out[4])
        rd("pa pulled", bpg_pkg::IDX_FIRST_PINS, 8'h3f);
        wr(bpg_pkg::IDX_ANALOG_CFG, 8'h00);
        `CHK("dir on analog", 6'h2f, pa_oe)
        rd("pa all analog", bpg_pkg::IDX_FIRST_PINS, 8'h10);
        wr(bpg_pkg::IDX_ANALOG_CFG, 8'h01);
        rd("pa part analog", bpg_pkg::IDX_FIRST_PINS, 8'h34);
        wr(bpg_pkg::IDX_ANALOG_CFG, 8'h06);
    endtask

    task automatic t_rmw_and_timer();
        logic [31:0] d;
        logic err;
        wr(bpg_pkg::IDX_FIRST_PINS, 8'h00);
        wr(bpg_pkg::IDX_FIRST_DIR, 8'h03);
        bpa_val <= 6'h03;
        bpa_en <= 6'h03;
        rd("pa mixed", bpg_pkg::IDX_FIRST_PINS, 8'h03);
        apb(1'b1, bpg_pkg::IDX_FIRST_PINS, 8'h00, 1'b0, d, err);
        bpa_en <= 6'h00;
        wr(bpg_pkg::IDX_FIRST_DIR, 8'h00);
        `CHK("rmw latch", 6'h03, pa_out)
        wr(bpg_pkg::IDX_PERIPH_SHARE, 8'h01);
        `CHK("timer owns pa4", 6'h2f, pa_oe)
        `CHK("timer clock high", 1'b1, tclk)
        bpa_val <= 6'h00;
        bpa_en <= 6'h10;
        cyc(2);
        `CHK("timer clock low", 1'b0, tclk)
        bpa_en <= 6'h00;
        wr(bpg_pkg::IDX_PERIPH_SHARE, 8'h00);
        wr(bpg_pkg::IDX_FIRST_DIR, 8'h3f);
    endtask

    task automatic t_second_port();
        logic [31:0] d;
        logic err;
        wr(bpg_pkg::IDX_SECOND_DIR, 8'hf0);
        bpb_en <= 8'hf0;
        bpb_val <= 8'h00;
        wr(bpg_pkg::IDX_SECOND_PINS, 8'h05);
        `CHK("pb oe", 8'h0f, pb_oe)
        `CHK("pb out", 8'h05, pb_out)
        rd("pb pins", bpg_pkg::IDX_SECOND_PINS, 8'h05);
        wr(bpg_pkg::IDX_OPTION_CONFIG, 8'h7f);
        `CHK("pullups on inputs", 8'hf0, pb_pu)
        wr(bpg_pkg::IDX_OPTION_CONFIG, 8'hff);
        `CHK("pullups off", 8'h00, pb_pu)
        bpb_val <= 8'hf0;
        apb(1'b1, bpg_pkg::IDX_SECOND_PINS, 8'h00, 1'b0, d, err);
        cyc(1);
        `CHK("pb rmw err", 1'b0, err)
        `CHK("pb rmw", 8'hf5, pb_out)
        // re-arm the snapshot at zero and drop the flag this raised
        bpb_val <= 8'h00;
        rd("pb rmw pins", bpg_pkg::IDX_SECOND_PINS, 8'h05);
        wr(bpg_pkg::IDX_IRQ_CONTROL, 8'h00);
    endtask

    // the port is read only where the sequence needs it, so the snapshot stays put
    task automatic t_change();
        int n;
        wr(bpg_pkg::IDX_SECOND_DIR, 8'hff);
        bpb_en <= 8'hff;
        bpb_val <= 8'h00;
        wr(bpg_pkg::IDX_IRQ_CONTROL, 8'h08);
        rd("pb snap", bpg_pkg::IDX_SECOND_PINS, 8'h00);
        bpb_val <= 8'h0f;
        cyc(4);
        rd("lower no change", bpg_pkg::IDX_IRQ_CONTROL, 8'h08);
        rd("pb snap2", bpg_pkg::IDX_SECOND_PINS, 8'h0f);
        bpb_val <= 8'h8f;
        n = 0;
        while (wake !== 1'b1 && n < 16)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK("wake on change", 1'b1, wake)
        wr(bpg_pkg::IDX_IRQ_CONTROL, 8'h08);
        rd("flag held", bpg_pkg::IDX_IRQ_CONTROL, 8'h09);
        rd("pb read ends", bpg_pkg::IDX_SECOND_PINS, 8'h8f);
        wr(bpg_pkg::IDX_IRQ_CONTROL, 8'h08);
        rd("flag cleared", bpg_pkg::IDX_IRQ_CONTROL, 8'h08);
        `CHK("wake gone", 1'b0, wake)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(12);
        presetn <= 1'b1;
        cyc(1);
        t_reset();
        t_first_port();
        t_rmw_and_timer();
        t_second_port();
        t_change();
        finish_test();
    end
endmodule // test_bpg_gpio_ports
`default_nettype wire
